// [rtl/lmpc_top.sv]
`timescale 1ns/1ps
// Playback control of the LED matrix driver.
module lmpc_top #(
    parameter int FRAME_STEP_CYC = lmpc_pkg::FRAME_STEP_CYC,
    parameter int BLINK_SHORT_CYC = lmpc_pkg::BLINK_SHORT_CYC,
    parameter int BLINK_LONG_CYC = lmpc_pkg::BLINK_LONG_CYC,
    parameter int DIGIT_CYC = lmpc_pkg::DIGIT_CYC
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire lmpc_pkg::lmpc_wr_t host_wr,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data_q,
    output lmpc_pkg::lmpc_view_t view_q,
    output logic movie_busy_q,
    output logic [3:0] current_sink_q,
    output logic current_sink_first_q,
    output logic current_sink_last_q,
    output logic [7:0] drive_level_q
);
    // Elaboration check: counters must be at least one cycle.
    if (FRAME_STEP_CYC < 1 || BLINK_SHORT_CYC < 1 || BLINK_LONG_CYC < BLINK_SHORT_CYC
        || DIGIT_CYC < 1)
    begin : g_bad
        $error("lmpc_top: timing parameters out of range");
    end

    // Control registers.
    logic [7:0] pic_q, mov_q, mode_q, tim_q, dsp_q, cur_q;
    // High once the host has selected the control bank.
    logic bank_ok_q;
    // Playback state.
    typedef enum logic [1:0] {ST_IDLE, ST_PIC, ST_MOVIE, ST_DONE} lmpc_st_t;
    lmpc_st_t st_q;
    logic [5:0] frame_q, step_q;
    logic [2:0] loop_q;
    logic [3:0] rep_q;
    logic [31:0] tick_q, blink_q, dig_q;
    logic blink_ph_q;
    logic mov_start_q;

    // Half the blink period in cycles for the selected period bit.
    function automatic logic [31:0] blink_half(input logic long_sel);
        blink_half = long_sel ? 32'(BLINK_LONG_CYC / 2) : 32'(BLINK_SHORT_CYC / 2);
    endfunction

    // Bank selection: writes only reach the control bank once it is selected.
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            bank_ok_q <= 1'b0;
        else if (ce && host_wr.wr && host_wr.addr == lmpc_pkg::OFS_BANK_SEL)
            bank_ok_q <= (host_wr.data == lmpc_pkg::BANK_CONTROL); // RULE19
    end

    // Register writes.
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            pic_q <= lmpc_pkg::RST_PICTURE;
            mov_q <= lmpc_pkg::RST_MOVIE;
            mode_q <= lmpc_pkg::RST_MODE;
            tim_q <= lmpc_pkg::RST_TIMING;
            dsp_q <= lmpc_pkg::RST_DISPLAY;
            cur_q <= lmpc_pkg::RST_CURRENT;
        end
        else if (ce && host_wr.wr && bank_ok_q)
        begin
            unique case (host_wr.addr)
                lmpc_pkg::OFS_PICTURE: pic_q <= host_wr.data;
                lmpc_pkg::OFS_MOVIE: mov_q <= host_wr.data;
                lmpc_pkg::OFS_MODE: mode_q <= host_wr.data;
                lmpc_pkg::OFS_TIMING: tim_q <= host_wr.data;
                lmpc_pkg::OFS_DISPLAY: dsp_q <= host_wr.data; // RULE14
                lmpc_pkg::OFS_CURRENT: cur_q <= host_wr.data;
                default: ;
            endcase
        end
    end

    // Readback of the control bank; other addresses read zero.
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            rd_data_q <= 8'h00;
        else if (ce)
        begin
            unique case (rd_addr)
                lmpc_pkg::OFS_PICTURE: rd_data_q <= pic_q;
                lmpc_pkg::OFS_MOVIE: rd_data_q <= mov_q;
                lmpc_pkg::OFS_MODE: rd_data_q <= mode_q;
                lmpc_pkg::OFS_TIMING: rd_data_q <= tim_q;
                lmpc_pkg::OFS_DISPLAY: rd_data_q <= dsp_q;
                lmpc_pkg::OFS_CURRENT: rd_data_q <= cur_q;
                default: rd_data_q <= 8'h00;
            endcase
        end
    end

    // Movie start request edge, so a new start restarts playback.
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            mov_start_q <= 1'b0;
        else if (ce)
            mov_start_q <= mov_q[lmpc_pkg::BIT_SIX];
    end

    // Playback sequencer.
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            st_q <= ST_IDLE;
            frame_q <= 6'h00;
            step_q <= 6'h00;
            loop_q <= 3'h0;
            rep_q <= 4'h0;
            tick_q <= 32'h0;
        end
        else if (ce)
        begin
            if (!mov_q[lmpc_pkg::BIT_SIX])
            begin
                // No movie: a picture or nothing.
                st_q <= pic_q[lmpc_pkg::BIT_SIX] ? ST_PIC : ST_IDLE; // RULE1 RULE4
                frame_q <= pic_q[5:0]; // RULE1
            end
            else if (!mov_start_q || st_q == ST_IDLE || st_q == ST_PIC)
            begin
                // Movie wins and starts at its first frame.
                st_q <= (dsp_q[7:5] == lmpc_pkg::LOOP_INVALID) ? ST_DONE : ST_MOVIE; // RULE3 RULE13
                frame_q <= mov_q[5:0]; // RULE4
                step_q <= 6'h00;
                loop_q <= 3'h1;
                rep_q <= 4'h0;
                tick_q <= 32'h0;
            end
            else if (st_q == ST_MOVIE)
            begin
                if (tick_q + 32'h1 < 32'(FRAME_STEP_CYC))
                    tick_q <= tick_q + 32'h1;
                else
                begin
                    tick_q <= 32'h0;
                    // Hold each frame for code steps; code zero plays it once.
                    if (rep_q + 4'h1 < tim_q[3:0]) // RULE9
                        rep_q <= rep_q + 4'h1;
                    else
                    begin
                        rep_q <= 4'h0;
                        if (step_q < mode_q[5:0]) // RULE8 RULE20
                        begin
                            step_q <= step_q + 6'h01;
                            frame_q <= frame_q + 6'h01;
                        end
                        else if (dsp_q[7:5] == lmpc_pkg::LOOP_ENDLESS || loop_q < dsp_q[7:5])
                        begin
                            // Another loop from the start frame.
                            if (dsp_q[7:5] != lmpc_pkg::LOOP_ENDLESS)
                                loop_q <= loop_q + 3'h1; // RULE13
                            step_q <= 6'h00;
                            frame_q <= mov_q[5:0]; // RULE20
                        end
                        else
                        begin
                            st_q <= ST_DONE;
                            // In scroll mode the end frame is chosen.
                            if (tim_q[lmpc_pkg::BIT_FOUR] && !mode_q[lmpc_pkg::BIT_SIX])
                                frame_q <= mov_q[5:0]; // RULE7
                        end
                    end
                end
            end
        end
    end

    // Blink phase generator.
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            blink_q <= 32'h0;
            blink_ph_q <= 1'b0;
        end
        else if (ce)
        begin
            if (blink_q + 32'h1 >= blink_half(dsp_q[lmpc_pkg::BIT_FOUR])) // RULE15
            begin
                blink_q <= 32'h0;
                blink_ph_q <= ~blink_ph_q;
            end
            else
                blink_q <= blink_q + 32'h1;
        end
    end

    // Scan of the current sinks, 0 to the scan limit.
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            dig_q <= 32'h0;
            current_sink_q <= 4'h0;
        end
        else if (ce)
        begin
            if (dig_q + 32'h1 >= 32'(DIGIT_CYC)) // RULE17
            begin
                dig_q <= 32'h0;
                if (current_sink_q >= dsp_q[3:0] || current_sink_q >= lmpc_pkg::SCAN_MAX)
                    current_sink_q <= 4'h0; // RULE16
                else
                    current_sink_q <= current_sink_q + 4'h1;
            end
            else
                dig_q <= dig_q + 32'h1;
        end
    end

    // Sink markers and drive level.
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            current_sink_first_q <= 1'b0;
            current_sink_last_q <= 1'b0;
            drive_level_q <= 8'h00;
        end
        else if (ce)
        begin
            current_sink_first_q <= (current_sink_q == 4'h0);
            current_sink_last_q <= (current_sink_q == lmpc_pkg::SCAN_MAX);
            drive_level_q <= cur_q; // RULE18
        end
    end

    // Displayed view.
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            view_q <= '0;
            movie_busy_q <= 1'b0;
        end
        else if (ce)
        begin
            view_q.on <= (st_q != ST_IDLE);
            view_q.frame <= frame_q;
            // Global blink only in its own mode, and never when disabled.
            view_q.blank <= blink_ph_q && !mode_q[lmpc_pkg::BIT_TOP] // RULE6
                && ((st_q == ST_PIC && pic_q[lmpc_pkg::BIT_TOP]) // RULE2
                || (st_q != ST_PIC && st_q != ST_IDLE && mov_q[lmpc_pkg::BIT_TOP])); // RULE5
            view_q.fade <= (st_q == ST_MOVIE) && tim_q[lmpc_pkg::BIT_TOP]
                && !(tim_q[lmpc_pkg::BIT_FOUR] && tim_q[lmpc_pkg::BIT_BLOCK]); // RULE10
            view_q.scroll <= (st_q == ST_MOVIE) && tim_q[lmpc_pkg::BIT_FOUR]; // RULE11
            view_q.scroll_left <= tim_q[lmpc_pkg::BIT_SIX]; // RULE11
            view_q.split <= tim_q[lmpc_pkg::BIT_BLOCK]; // RULE12
            movie_busy_q <= (st_q == ST_MOVIE);
        end
    end

    // A requested movie keeps the static picture off the matrix.
    a_movie_wins: assert property (@(posedge mclk) disable iff (!rstn) // RULE3
        ce && mov_q[lmpc_pkg::BIT_SIX] && pic_q[lmpc_pkg::BIT_SIX] && $past(mov_q[lmpc_pkg::BIT_SIX])
        |=> st_q != ST_PIC)
        else $error("picture shown while movie requested");
    // The blink disable bit darkens nothing on the next cycle.
    a_blink_off: assert property (@(posedge mclk) disable iff (!rstn) // RULE6
        ce && mode_q[lmpc_pkg::BIT_TOP] |=> !view_q.blank || !$past(ce))
        else $error("blink while disabled");
    // The scan never reaches past the last sink.
    a_scan_bound: assert property (@(posedge mclk) disable iff (!rstn) // RULE16
        current_sink_q <= lmpc_pkg::SCAN_MAX)
        else $error("sink beyond last");
    // With neither picture nor movie requested the matrix goes dark.
    a_idle_off: assert property (@(posedge mclk) disable iff (!rstn) // RULE1
        ce && !mov_q[lmpc_pkg::BIT_SIX] && !pic_q[lmpc_pkg::BIT_SIX] ##1 ce |=> !view_q.on)
        else $error("display on with nothing selected");
    // The picture bit alone selects the picture state and the addressed frame on the next cycle.
    a_picture_frame: assert property (@(posedge mclk) disable iff (!rstn) // RULE1
        ce && !mov_q[lmpc_pkg::BIT_SIX] && pic_q[lmpc_pkg::BIT_SIX]
        |=> st_q == ST_PIC && frame_q == $past(pic_q[5:0]))
        else $error("picture frame not shown");
    // A fresh movie request starts playback at its start frame.
    a_movie_start: assert property (@(posedge mclk) disable iff (!rstn) // RULE4
        ce && mov_q[lmpc_pkg::BIT_SIX] && !mov_start_q && dsp_q[7:5] != lmpc_pkg::LOOP_INVALID
        |=> st_q == ST_MOVIE && frame_q == $past(mov_q[5:0]))
        else $error("movie not started at its first frame");
endmodule

// [rtl/lmpc_pkg.sv]
// Function
// [RULE1] Picture bit shows stored frame statically
// [RULE2] Picture blink bit blinks whole matrix
// [RULE3] Movie bit wins over picture bit
// [RULE4] Movie bit starts playback at start frame
// [RULE5] Movie blink bit blinks whole matrix
// [RULE6] Blink disable bit suppresses every blink
// [RULE7] Scroll movie ends first or last frame
// [RULE8] Frame count field sets frames minus one
// [RULE9] Frame delay code times 32.5 ms
// [RULE10] Fade between frames unless split blocks
// [RULE11] Scroll enable and direction during movie
// [RULE12] Block size picks full or split scrolling
// [RULE13] Loop field sets repeats, seven is endless
// [RULE14] Host rewrites loop field to stop endless
// [RULE15] Blink period 1.5 s or 3 s
// [RULE16] Scan limit scans sinks zero through N
// [RULE17] Full scan near 430 Hz, fewer faster
// [RULE18] Current code scales drive linearly
// [RULE19] Host selects control bank before access
// [RULE20] Step frames, wrap per loop, stop at count
package lmpc_pkg;
    // Register offsets within the control bank.
    localparam logic [7:0] OFS_PICTURE = 8'h00;
    localparam logic [7:0] OFS_MOVIE = 8'h01;
    localparam logic [7:0] OFS_MODE = 8'h02;
    localparam logic [7:0] OFS_TIMING = 8'h03;
    localparam logic [7:0] OFS_DISPLAY = 8'h04;
    localparam logic [7:0] OFS_CURRENT = 8'h05;
    // Bank selection address and the value that picks the control bank.
    localparam logic [7:0] OFS_BANK_SEL = 8'hFD;
    localparam logic [7:0] BANK_CONTROL = 8'hC0;
    // Reset values.
    localparam logic [7:0] RST_PICTURE = 8'h00;
    localparam logic [7:0] RST_MOVIE = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_TIMING = 8'h00;
    localparam logic [7:0] RST_DISPLAY = 8'h20;
    localparam logic [7:0] RST_CURRENT = 8'h00;
    // Field positions; all but BIT_BLOCK are shared by several registers.
    localparam int BIT_TOP = 7;
    localparam int BIT_SIX = 6;
    localparam int BIT_BLOCK = 5;
    localparam int BIT_FOUR = 4;
    // Loop codes.
    localparam logic [2:0] LOOP_INVALID = 3'h0;
    localparam logic [2:0] LOOP_ENDLESS = 3'h7;
    // Highest scan limit code (sinks 0..11).
    localparam logic [3:0] SCAN_MAX = 4'hB;
    // Timing in its own units and the clock rate.
    localparam int CLK_HZ = 50000000;
    localparam int FRAME_STEP_US = 32500;
    localparam int BLINK_SHORT_MS = 1500;
    localparam int BLINK_LONG_MS = 3000;
    localparam int SCAN_FULL_HZ = 430;
    localparam int SCAN_DIGITS = 12;
    // Derived cycle counts (the digit slot rounds down).
    localparam int FRAME_STEP_CYC = (CLK_HZ / 1000) * FRAME_STEP_US / 1000;
    localparam int BLINK_SHORT_CYC = (CLK_HZ / 1000) * BLINK_SHORT_MS;
    localparam int BLINK_LONG_CYC = (CLK_HZ / 1000) * BLINK_LONG_MS;
    localparam int DIGIT_CYC = CLK_HZ / (SCAN_FULL_HZ * SCAN_DIGITS);

    // One host register write.
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } lmpc_wr_t;

    // What the matrix shows.
    typedef struct packed {
        logic       on;
        logic [5:0] frame;
        logic       blank;
        logic       fade;
        logic       scroll;
        logic       scroll_left;
        logic       split;
    } lmpc_view_t;
endpackage

// [sim/lmpc_host.sv]
`timescale 1ns/1ps
// Host model: writes one control byte per strobe, with a gap cycle between writes.
module lmpc_host (
    input wire logic mclk,
    output lmpc_pkg::lmpc_wr_t host_wr
);
    // The bus is idle with no strobe until the first write.
    initial host_wr = '0;

    // Holds the write for the one edge that takes it, then scrambles the idle bus.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        begin
            @(posedge mclk);
            host_wr <= '{wr: 1'b1, addr: a, data: d};
            @(posedge mclk);
            host_wr <= '{wr: 1'b0, addr: ~a, data: ~d};
        end
    endtask

    // Picks the control bank before any control access.
    task automatic sel();
        begin
            wr(lmpc_pkg::OFS_BANK_SEL, lmpc_pkg::BANK_CONTROL);
        end
    endtask
endmodule

// [sim/tb_lmpc_top.sv]
`timescale 1ns/1ps
// Compares two values and counts the outcome.
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
// Drives the playback control through host writes and watches what it shows.
module tb_lmpc_top;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic [7:0] rd_addr = 8'h00;
    lmpc_pkg::lmpc_wr_t host_wr;
    lmpc_pkg::lmpc_view_t view_q;
    logic movie_busy_q, current_sink_first_q, current_sink_last_q;
    logic [3:0] current_sink_q;
    logic [7:0] rd_data_q, drive_level_q, exp_v, cur;
    logic [7:0] exp_q[$];
    logic rd_go = 1'b0;
    logic rd_seen = 1'b0;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    int t0, t1;

    lmpc_host lmpc_host_i (.mclk(mclk), .host_wr(host_wr));
    // Short counts keep frame steps, blink phases and digit slots a few cycles long.
    lmpc_top #(.FRAME_STEP_CYC(4), .BLINK_SHORT_CYC(8), .BLINK_LONG_CYC(16), .DIGIT_CYC(2))
    lmpc_top_i (.mclk(mclk), .rstn(rstn), .ce(ce), .host_wr(host_wr), .rd_addr(rd_addr),
        .rd_data_q(rd_data_q), .view_q(view_q), .movie_busy_q(movie_busy_q),
        .current_sink_q(current_sink_q), .current_sink_first_q(current_sink_first_q),
        .current_sink_last_q(current_sink_last_q), .drive_level_q(drive_level_q));

    // The clock toggles every half period of 10 ns.
    initial forever #10 mclk = ~mclk;

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        begin
            $display("checks %0d err_count %0d", checks, err_count);
            if (err_count == 0 && checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    // A hung wait is cut short and counted as a mismatch.
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            err_count++;
            complete_run();
        end
    end

    // Readback lands one edge after the address, so the note is taken off a cycle late.
    always @(negedge mclk)
    begin
        if (rd_seen)
        begin
            exp_v = exp_q.pop_front();
            `CHK("rd_data_q", exp_v, rd_data_q)
        end
        rd_seen = rd_go;
    end

    // Presents a read address for one cycle and notes the value it should return.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        begin
            @(posedge mclk);
            rd_addr <= a;
            rd_go <= 1'b1;
            exp_q.push_back(e);
            @(posedge mclk);
            rd_go <= 1'b0;
        end
    endtask

    // Shorthand for one host write.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        lmpc_host_i.wr(a, d);
    endtask

    // Counts changes of the dark phase over n cycles.
    task automatic blinks(input int n, output int t);
        logic p;
        begin
            t = 0;
            // Lets the last register write reach the view before the first sample.
            repeat (2) @(negedge mclk);
            p = view_q.blank;
            repeat (n)
            begin
                @(negedge mclk);
                if (view_q.blank !== p) t++;
                p = view_q.blank;
            end
        end
    endtask

    // Sets a scan limit and watches the sink sweep stay within it.
    task automatic scan(input logic [3:0] n);
        logic [3:0] mx;
        logic bad, fst, lst;
        int z;
        begin
            wr(lmpc_pkg::OFS_DISPLAY, {4'h2, n});
            repeat (30) @(negedge mclk);
            mx = 4'h0;
            // Cycles spent on the first sink; a shorter sweep revisits it more often.
            z = 0;
            bad = 1'b0;
            fst = 1'b0;
            lst = 1'b0;
            repeat (80)
            begin
                @(negedge mclk);
                bad |= (current_sink_q > n);
                if (current_sink_q > mx) mx = current_sink_q;
                fst |= (current_sink_first_q === 1'b1);
                lst |= (current_sink_last_q === 1'b1);
                if (current_sink_q == 4'h0) z++;
            end
            `CHK("scan top", n, mx)
            `CHK("scan over", 1'b0, bad)
            `CHK("first sink", 1'b1, fst)
            `CHK("last sink", n == lmpc_pkg::SCAN_MAX, lst)
            `CHK("scan rate", 1'b1, z * (n + 1) >= 80 - 4 * (n + 1) && z * (n + 1) <= 80 + 4 * (n + 1))
        end
    endtask

    // Plays a counted movie and checks start, top frame, wraps and length.
    task automatic movie(input logic [5:0] st, cnt, input logic [3:0] dl, input logic [2:0] lp);
        logic [5:0] mx, pf;
        int k, w, d, e;
        begin
            e = lp * (cnt + 1) * ((dl == 4'h0) ? 1 : dl) * 4;
            wr(lmpc_pkg::OFS_TIMING, {4'h0, dl});
            wr(lmpc_pkg::OFS_MODE, {2'h0, cnt});
            wr(lmpc_pkg::OFS_DISPLAY, {lp, 5'h00});
            wr(lmpc_pkg::OFS_MOVIE, {2'h1, st});
            k = 0;
            while (movie_busy_q !== 1'b1 && k < 20)
            begin
                @(negedge mclk);
                k++;
            end
            `CHK("start frame", st, view_q.frame)
            mx = st;
            pf = st;
            w = 0;
            d = 0;
            while (movie_busy_q === 1'b1 && d < 600)
            begin
                if (view_q.frame > mx) mx = view_q.frame;
                if (view_q.frame < pf) w++;
                pf = view_q.frame;
                d++;
                @(negedge mclk);
            end
            `CHK("top frame", st + cnt, mx)
            `CHK("wraps", lp - 1, w)
            `CHK("length", 1'b1, d >= e - 3 && d <= e + 3)
            wr(lmpc_pkg::OFS_MOVIE, 8'h00);
        end
    endtask

    // Main sequence: reset, registers, scan, picture, blink, movies, endless play.
    initial
    begin
        void'($urandom(32'hbe896746));
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        wr(lmpc_pkg::OFS_CURRENT, 8'h5A);
        lmpc_host_i.sel();
        for (int i = 0; i < 7; i++) rd(8'(i), (i == 4) ? 8'h20 : 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            cur = (i == 0) ? 8'hFF : 8'($urandom());
            wr(lmpc_pkg::OFS_CURRENT, cur);
            rd(lmpc_pkg::OFS_CURRENT, cur);
            @(negedge mclk);
            `CHK("drive level", cur, drive_level_q)
        end
        wr(lmpc_pkg::OFS_BANK_SEL, 8'h00);
        wr(lmpc_pkg::OFS_CURRENT, 8'h11);
        lmpc_host_i.sel();
        rd(lmpc_pkg::OFS_CURRENT, cur);
        scan(lmpc_pkg::SCAN_MAX);
        scan(4'h3);
        scan(4'h0);
        wr(lmpc_pkg::OFS_PICTURE, 8'h43);
        blinks(64, t0);
        `CHK("picture", 7'h43, {view_q.on, view_q.frame})
        `CHK("steady", 0, t0)
        wr(lmpc_pkg::OFS_PICTURE, 8'hC3);
        blinks(96, t0);
        wr(lmpc_pkg::OFS_DISPLAY, 8'h30);
        blinks(96, t1);
        `CHK("blink period", 1'b1, t0 > t1 && t1 > 0)
        wr(lmpc_pkg::OFS_MODE, 8'h80);
        blinks(64, t0);
        `CHK("blink off", 0, t0)
        movie(6'($urandom_range(3)), 6'h01, 4'h1, 3'h1);
        movie(6'h00, 6'h02, 4'h2, 3'h2);
        movie(6'h01, 6'h03, 4'h0, 3'h5);
        wr(lmpc_pkg::OFS_MODE, 8'h42);
        wr(lmpc_pkg::OFS_DISPLAY, 8'hE0);
        wr(lmpc_pkg::OFS_MOVIE, 8'hC2);
        blinks(300, t0);
        `CHK("endless", 1'b1, movie_busy_q)
        `CHK("movie blink", 1'b1, t0 > 0)
        // With the clock enable low the blinking view must freeze.
        @(posedge mclk);
        ce <= 1'b0;
        blinks(20, t1);
        `CHK("frozen blink", 0, t1)
        `CHK("frozen busy", 1'b1, movie_busy_q)
        @(posedge mclk);
        ce <= 1'b1;
        wr(lmpc_pkg::OFS_TIMING, 8'hD1);
        blinks(4, t1);
        `CHK("scroll left", 4'hE, view_q[3:0])
        wr(lmpc_pkg::OFS_TIMING, 8'hF1);
        blinks(4, t1);
        `CHK("split", 4'h7, view_q[3:0])
        wr(lmpc_pkg::OFS_TIMING, 8'h11);
        blinks(4, t1);
        `CHK("scroll right", 4'h4, view_q[3:0])
        wr(lmpc_pkg::OFS_DISPLAY, 8'h20);
        t0 = 0;
        while (movie_busy_q === 1'b1 && t0 < 400)
        begin
            @(negedge mclk);
            t0++;
        end
        `CHK("stopped", 1'b0, movie_busy_q)
        `CHK("end frame", 6'h04, view_q.frame)
        // A scrolled movie with the end select low stops on its first frame.
        wr(lmpc_pkg::OFS_MOVIE, 8'h00);
        wr(lmpc_pkg::OFS_MODE, 8'h02);
        wr(lmpc_pkg::OFS_MOVIE, 8'h42);
        repeat (40) @(negedge mclk);
        `CHK("end first", 7'h42, {view_q.on, view_q.frame})
        `CHK("first stopped", 1'b0, movie_busy_q)
        complete_run();
    end
endmodule
